//--- logic/lbse_pkg.sv
// shared constants and types for the ladder bit stack evaluator
package lbse_pkg;
   // ==========================================================
   // instruction word layout
   localparam int INSTR_W   = 20;
   localparam int OP_HI     = 19;
   localparam int OP_LO     = 16;
   localparam int AREA_HI   = 15;
   localparam int AREA_LO   = 13;
   localparam int BYTE_HI   = 12;
   localparam int BYTE_LO   = 3;
   localparam int BIT_HI    = 2;
   localparam int BIT_LO    = 0;
   localparam int PC_W      = 10;
   localparam int STACK_D   = 8;
   // ==========================================================
   // opcodes
   typedef enum logic [3:0] {
      OP_NOP        = 4'h0,
      OP_LOAD       = 4'h1,
      OP_LOAD_INV   = 4'h2,
      OP_AND        = 4'h3,
      OP_AND_INV    = 4'h4,
      OP_OR         = 4'h5,
      OP_OR_INV     = 4'h6,
      OP_STORE      = 4'h7,
      OP_STORE_INV  = 4'h8,
      OP_STACK_OR   = 4'h9,
      OP_STACK_AND  = 4'hA,
      OP_JUMP_LABEL = 4'hB,
      OP_LABEL_DECL = 4'hC,
      OP_CALL_SUB   = 4'hD,
      OP_SUB_BEGIN  = 4'hE,
      OP_END_SCAN   = 4'hF
   } lbse_op_t;
   // ==========================================================
   // signal areas
   localparam logic [2:0] AREA_INPUT    = 3'h0;
   localparam logic [2:0] AREA_FROM_CNC = 3'h4;
   // ==========================================================
   // word areas
   localparam int WORD_W      = 16;
   localparam int TMR_N       = 128;
   localparam int CNT_N       = 128;
   localparam int TABLE_N     = 256;
   localparam int TMR_AW      = 7;
   localparam int TABLE_AW    = 8;
   localparam int OPERAND_MAX = 99;
   localparam logic [1:0] SEL_TMR_CUR  = 2'h0;
   localparam logic [1:0] SEL_TMR_PRE  = 2'h1;
   localparam logic [1:0] SEL_CNT_PRE  = 2'h2;
   localparam logic [1:0] SEL_TABLE    = 2'h3;
   // ==========================================================
   // sequencer states, gray along idle -> run -> end of scan
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_RUN     = 2'b01,
      ST_ENDSCAN = 2'b11
   } lbse_state_t;
endpackage

//--- logic/lbse_evaluator.sv
// ladder bit stack evaluator: basic relay instructions and word areas
`timescale 1ns/10ps

// Notes on behaviour
// - load shifts stack toward older end, then puts addressed signal in top bit
// - inverted load does the same with the complement of the signal
// - store writes the top stack bit to the addressed output or relay bit
// - inverted store writes the complement of the top stack bit
// - back-to-back stores each drive their coil from the unchanged result
// - series contact ANDs top bit with signal or its complement, unlimited
// - parallel contact ORs top bit with signal or its complement
// - stack-or ORs top two bits then pops, result becomes top
// - stack-and ANDs top two bits then pops, result becomes top
// - stack-combining instructions fetch and interpret no operand
// - 128 timer current entries, restored to preset after power loss
// - 128 counter preset entries, retained, read-only to the program
// - 128 timer preset entries, retained, read-only to the program
// - 256 data table entries retained across power loss
// - jump and label operands accepted only from 0 to 99
// - subprogram operands of call and declaration accepted only 0 to 99
// - first scan flag set on start, cleared after one full scan
module lbse_evaluator
   import lbse_pkg::*;
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // run control
   input  wire logic                 runEnable,
   output logic                      running,
   output logic                      first_scan_flag,
   output logic                      scanDone,
   // program fetch
   output logic [PC_W-1:0]           pc,
   input  wire logic [INSTR_W-1:0]   instr,
   // signal read lookup
   output logic                      sigRdEn,
   output logic [2:0]                sigArea,
   output logic [BYTE_HI-BYTE_LO:0]  sigByte,
   output logic [2:0]                sigBit,
   input  wire logic                 sigValue,
   // coil write
   output logic                      coilWrEn,
   output logic [2:0]                coilArea,
   output logic [BYTE_HI-BYTE_LO:0]  coilByte,
   output logic [2:0]                coilBit,
   output logic                      coilData,
   // operand faults
   output logic                      operandErr,
   output logic                      illegalStore,
   // stack view
   output logic [STACK_D-1:0]        stack_top_view,
   // word area access from the program side
   input  wire logic                 areaRdEn,
   input  wire logic                 areaWrEn,
   input  wire logic [1:0]           areaSel,
   input  wire logic [TABLE_AW-1:0]  areaAddr,
   input  wire logic [WORD_W-1:0]    areaWrData,
   output logic [WORD_W-1:0]         areaRdData,
   output logic                      areaRdValid,
   output logic                      areaWrRefused,
   // preset setup from the system side
   input  wire logic                 presetLoadEn,
   input  wire logic                 presetLoadCounter,
   input  wire logic [TMR_AW-1:0]    presetLoadAddr,
   input  wire logic [WORD_W-1:0]    presetLoadData
);

   // ==========================================================
   // functions
   function automatic logic in_range99(input logic [BYTE_HI-BYTE_LO:0] v);
      in_range99 = (v <= (BYTE_HI-BYTE_LO+1)'(OPERAND_MAX));
   endfunction

   function automatic logic legal_dest(input logic [2:0] a);
      legal_dest = (a != AREA_INPUT) && (a != AREA_FROM_CNC);
   endfunction

   // ==========================================================
   // state and storage
   lbse_state_t                state;
   lbse_state_t                next_state;
   logic [STACK_D-1:0]         stack;
   logic [STACK_D-1:0]         next_stack;
   logic [PC_W-1:0]            next_pc;

   // arrays carry no reset so retained areas keep their contents
   logic [WORD_W-1:0]          tmrCur   [TMR_N];
   logic [WORD_W-1:0]          tmrPre   [TMR_N];
   logic [WORD_W-1:0]          cntPre   [CNT_N];
   logic [WORD_W-1:0]          dataTbl  [TABLE_N];
   logic [TMR_N-1:0]           tmrLive;

   // ==========================================================
   // decode
   wire lbse_op_t               op        = lbse_op_t'(instr[OP_HI:OP_LO]);
   wire logic                   exec      = (state == ST_RUN);
   wire logic [2:0]             opArea    = instr[AREA_HI:AREA_LO];
   wire logic [BYTE_HI-BYTE_LO:0] opByte  = instr[BYTE_HI:BYTE_LO];
   wire logic [2:0]             opBit     = instr[BIT_HI:BIT_LO];
   wire logic                   isLoad    = (op == OP_LOAD) || (op == OP_LOAD_INV);
   wire logic                   isAnd     = (op == OP_AND) || (op == OP_AND_INV);
   wire logic                   isOr      = (op == OP_OR) || (op == OP_OR_INV);
   wire logic                   isStore   = (op == OP_STORE) || (op == OP_STORE_INV);
   wire logic                   isInv     = (op == OP_LOAD_INV) || (op == OP_AND_INV) ||
                                            (op == OP_OR_INV);
   wire logic                   isStackOp = (op == OP_STACK_OR) || (op == OP_STACK_AND);
   wire logic                   isLblOp   = (op == OP_JUMP_LABEL) || (op == OP_LABEL_DECL);
   wire logic                   isSubOp   = (op == OP_CALL_SUB) || (op == OP_SUB_BEGIN);
   wire logic                   isEnd     = (op == OP_END_SCAN);
   // contact operand read only for contact ops, never for stack ops
   wire logic                   needsSig  = isLoad || isAnd || isOr;
   wire logic                   contact   = sigValue ^ isInv;
   wire logic                   storeOk   = legal_dest(opArea);
   // label space shared by jump and declaration
   wire logic                   lblBad    = isLblOp && !in_range99(opByte);
   // subprogram number space for call and declaration
   wire logic                   subBad    = isSubOp && !in_range99(opByte);

   // ==========================================================
   // signal lookup is combinational so one op retires per clock
   assign sigRdEn        = exec && needsSig;
   assign sigArea        = needsSig ? opArea : 3'h0;
   assign sigByte        = needsSig ? opByte : '0;
   assign sigBit         = needsSig ? opBit : 3'h0;
   assign running        = exec;
   assign stack_top_view = stack;

   // ==========================================================
   // stack next value
   always_comb begin
      next_stack = stack;
      if (exec) begin
         unique case (op)
            OP_LOAD, OP_LOAD_INV: begin
               next_stack = {stack[STACK_D-2:0], contact};
            end
            OP_AND, OP_AND_INV: begin
               next_stack = {stack[STACK_D-1:1], stack[0] & contact};
            end
            OP_OR, OP_OR_INV: begin
               next_stack = {stack[STACK_D-1:1], stack[0] | contact};
            end
            OP_STACK_OR: begin
               next_stack = {1'b0, stack[STACK_D-1:2], stack[1] | stack[0]};
            end
            OP_STACK_AND: begin
               next_stack = {1'b0, stack[STACK_D-1:2], stack[1] & stack[0]};
            end
            // stores leave the result untouched for the next coil
            OP_STORE, OP_STORE_INV: begin
               next_stack = stack;
            end
            OP_NOP, OP_JUMP_LABEL, OP_LABEL_DECL, OP_CALL_SUB,
            OP_SUB_BEGIN, OP_END_SCAN: begin
               next_stack = stack;
            end
         endcase
      end
   end

   // ==========================================================
   // sequencer
   always_comb begin
      next_state = state;
      next_pc    = pc;
      unique case (state)
         ST_IDLE: begin
            if (runEnable) begin
               next_state = ST_RUN;
            end
            next_pc = '0;
         end
         ST_RUN: begin
            if (isEnd) begin
               next_state = ST_ENDSCAN;
               next_pc    = '0;
            end else begin
               next_pc = pc + PC_W'(1);
            end
         end
         ST_ENDSCAN: begin
            next_state = runEnable ? ST_RUN : ST_IDLE;
            next_pc    = '0;
         end
         default: begin
            next_state = ST_IDLE;
            next_pc    = '0;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         pc    <= '0;
         stack <= '0;
      end else begin
         state <= next_state;
         pc    <= next_pc;
         stack <= next_stack;
      end
   end

   // ==========================================================
   // first scan flag: set by every start, dropped at end of scan
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_scan_flag <= 1'b1;
         scanDone        <= 1'b0;
      end else begin
         scanDone <= (state == ST_ENDSCAN);
         if (state == ST_ENDSCAN) begin
            first_scan_flag <= 1'b0;
         end else if (state == ST_IDLE && runEnable) begin
            first_scan_flag <= 1'b1;
         end
      end
   end

   // ==========================================================
   // coil write, registered; input areas are never driven
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coilWrEn     <= 1'b0;
         coilArea     <= 3'h0;
         coilByte     <= '0;
         coilBit      <= 3'h0;
         coilData     <= 1'b0;
         illegalStore <= 1'b0;
         operandErr   <= 1'b0;
      end else begin
         coilWrEn     <= exec && isStore && storeOk;
         illegalStore <= exec && isStore && !storeOk;
         operandErr   <= exec && (lblBad || subBad);
         if (exec && isStore) begin
            coilArea <= opArea;
            coilByte <= opByte;
            coilBit  <= opBit;
            coilData <= stack[0] ^ (op == OP_STORE_INV);
         end
      end
   end

   // ==========================================================
   // word areas
   wire logic [TMR_AW-1:0]  tAddr    = areaAddr[TMR_AW-1:0];
   // addresses past 127 miss the 128-entry areas
   wire logic               tInRange = (areaAddr < TABLE_AW'(TMR_N));
   wire logic               wrTmr    = areaWrEn && areaSel == SEL_TMR_CUR && tInRange;
   wire logic               wrTable  = areaWrEn && areaSel == SEL_TABLE;
   // presets take no program write
   wire logic               wrBad    = areaWrEn && (areaSel == SEL_TMR_PRE ||
                                        areaSel == SEL_CNT_PRE ||
                                        (areaSel == SEL_TMR_CUR && !tInRange));
   wire logic [WORD_W-1:0]  tCurRaw  = tmrCur[tAddr];
   wire logic [WORD_W-1:0]  tPreVal  = tmrPre[tAddr];
   // unwritten since reset or zero reads as the preset
   wire logic [WORD_W-1:0]  tCurVal  = (!tmrLive[tAddr] || tCurRaw == '0) ? tPreVal : tCurRaw;

   logic [WORD_W-1:0] rdMux;
   always_comb begin
      rdMux = '0;
      unique case (areaSel)
         SEL_TMR_CUR: rdMux = tInRange ? tCurVal : '0;
         SEL_TMR_PRE: rdMux = tInRange ? tPreVal : '0;
         SEL_CNT_PRE: rdMux = tInRange ? cntPre[tAddr] : '0;
         SEL_TABLE:   rdMux = dataTbl[areaAddr];
      endcase
   end

   // live bits lost on reset emulate a power loss restoring presets
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tmrLive       <= '0;
         areaRdData    <= '0;
         areaRdValid   <= 1'b0;
         areaWrRefused <= 1'b0;
      end else begin
         areaRdValid   <= areaRdEn;
         areaWrRefused <= wrBad;
         if (areaRdEn) begin
            areaRdData <= rdMux;
         end
         if (wrTmr) begin
            tmrLive[tAddr] <= 1'b1;
         end
      end
   end

   // array writes; no reset so retained areas survive
   always_ff @(posedge clk) begin
      if (wrTmr) begin
         tmrCur[tAddr] <= areaWrData;
      end
      if (wrTable) begin
         dataTbl[areaAddr] <= areaWrData;
      end
      if (presetLoadEn && !presetLoadCounter) begin
         tmrPre[presetLoadAddr] <= presetLoadData;
      end
      if (presetLoadEn && presetLoadCounter) begin
         cntPre[presetLoadAddr] <= presetLoadData;
      end
   end

endmodule

//--- tb/lbse_evaluator_sva.sv
// port assertions for the ladder bit stack evaluator
`timescale 1ns/10ps
// ==========================================================
// checker
module lbse_evaluator_chk
   import lbse_pkg::*;
(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // sequencing
   input  wire logic                running,
   input  wire logic                first_scan_flag,
   input  wire logic                scanDone,
   input  wire logic [PC_W-1:0]     pc,
   input  wire logic [INSTR_W-1:0]  instr,
   // signals, coils, stack
   input  wire logic                sigRdEn,
   input  wire logic                sigValue,
   input  wire logic                coilWrEn,
   input  wire logic                coilData,
   input  wire logic [STACK_D-1:0]  stack_top_view
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire [3:0] op    = instr[OP_HI:OP_LO];
   wire [2:0] ar    = instr[AREA_HI:AREA_LO];
   wire [7:0] s     = stack_top_view;
   wire       v     = sigValue;
   wire       t0    = s[0];
   wire       ok    = (ar != AREA_INPUT) && (ar != AREA_FROM_CNC);
   wire [7:0] nLd   = {s[6:0], v};
   wire [7:0] nLdN  = {s[6:0], ~v};
   wire [7:0] nAnd  = {s[7:1], s[0] & (v ^ (op == OP_AND_INV))};
   wire [7:0] nOr   = {s[7:1], s[0] | (v ^ (op == OP_OR_INV))};
   wire [7:0] nSOr  = {1'b0, s[7:2], s[1] | s[0]};
   wire [7:0] nSAnd = {1'b0, s[7:2], s[1] & s[0]};
   ld_push_a: assert property (running && op == OP_LOAD |=> s == $past(nLd))
      else $error("load push wrong");
   ld_inv_a: assert property (running && op == OP_LOAD_INV |=> s == $past(nLdN))
      else $error("inverted load push wrong");
   ser_and_a: assert property (running && (op == OP_AND || op == OP_AND_INV) |=>
      s == $past(nAnd)) else $error("series contact wrong");
   par_or_a: assert property (running && (op == OP_OR || op == OP_OR_INV) |=>
      s == $past(nOr)) else $error("parallel contact wrong");
   stk_or_a: assert property (running && op == OP_STACK_OR |=> s == $past(nSOr))
      else $error("stack or merge wrong");
   stk_and_a: assert property (running && op == OP_STACK_AND |=> s == $past(nSAnd))
      else $error("stack and merge wrong");
   store_coil_a: assert property (running && op == OP_STORE && ok |=>
      coilWrEn && coilData == $past(t0) && $stable(s)) else $error("store coil wrong");
   store_inv_a: assert property (running && op == OP_STORE_INV && ok |=>
      coilWrEn && coilData == !$past(t0) && $stable(s)) else $error("inverted store wrong");
   no_operand_a: assert property (running && (op == OP_STACK_OR || op == OP_STACK_AND)
      |-> !sigRdEn) else $error("stack merge fetched an operand");
   pc_step_a: assert property (running && op inside {[OP_LOAD:OP_STACK_AND]} |=>
      pc == $past(pc) + 10'h001) else $error("program order broken");
   scan_flag_a: assert property (scanDone |-> !first_scan_flag)
      else $error("first scan flag still set");
   scan_start_a: assert property ($rose(running) && !scanDone |-> first_scan_flag)
      else $error("first scan flag not set at start");
   rst_clear_a: assert property ($rose(rst_n) |-> s == 8'h00)
      else $error("stack not cleared by reset");
   cover property (running && op == OP_STACK_AND);
   cover property (running && op == OP_STORE_INV ##1 coilWrEn);
   cover property (scanDone);
endmodule

bind lbse_evaluator lbse_evaluator_chk lbse_evaluator_chk_inst (
   .clk(clk), .rst_n(rst_n), .running(running), .first_scan_flag(first_scan_flag),
   .scanDone(scanDone), .pc(pc), .instr(instr), .sigRdEn(sigRdEn), .sigValue(sigValue),
   .coilWrEn(coilWrEn), .coilData(coilData), .stack_top_view(stack_top_view));

//--- tb/lbse_ladder_env.sv
// program store and signal memory facing the evaluator
`timescale 1ns/10ps
// ==========================================================
// partner model
module lbse_ladder_env
   import lbse_pkg::*;
(
   // clock
   input  wire logic                      clk,
   // program fetch
   input  wire logic [PC_W-1:0]           pc,
   output logic [INSTR_W-1:0]             instr,
   // signal lookup
   input  wire logic                      sigRdEn,
   input  wire logic [2:0]                sigArea,
   input  wire logic [BYTE_HI-BYTE_LO:0]  sigByte,
   input  wire logic [2:0]                sigBit,
   output logic                           sigValue
);
   logic [INSTR_W-1:0] prog [0:63];
   logic               junk;
   // beyond the loaded words the program ends the scan
   assign instr = (pc < 10'h040) ? prog[pc[5:0]] : {OP_END_SCAN, 16'h0000};
   // idle line toggles so a stale value can never pass
   // areas other than 2 read inverted so a wrong area shows up in the stack
   assign sigValue = sigRdEn ? (sigByte[0] ^ sigBit[0] ^ (sigArea != 3'h2)) : junk;
   initial junk = 1'b0;
   always @(posedge clk) junk <= ~junk;
endmodule

//--- tb/test_ladder_bit_stack_evaluator.sv
// self-checking bench for the ladder bit stack evaluator
`timescale 1ns/10ps
// ==========================================================
// bench top
module test_ladder_bit_stack_evaluator
   import lbse_pkg::*;
;
   logic clk, rst_n, runEnable, running, first_scan_flag, scanDone, sigRdEn, sigValue;
   logic coilWrEn, coilData, operandErr, illegalStore, areaRdEn, areaWrEn, areaRdValid;
   logic areaWrRefused, presetLoadEn, presetLoadCounter;
   logic [PC_W-1:0] pc;
   logic [INSTR_W-1:0] instr;
   logic [BYTE_HI-BYTE_LO:0] sigByte, coilByte;
   logic [2:0] sigArea, sigBit, coilArea, coilBit;
   logic [STACK_D-1:0] stack_top_view;
   logic [1:0] areaSel;
   logic [TABLE_AW-1:0] areaAddr;
   logic [WORD_W-1:0] areaWrData, areaRdData, presetLoadData;
   logic [TMR_AW-1:0] presetLoadAddr;
   int n_mismatch, n_compared, cycles, nErr, nIll;
   logic [16:0] coils [$];
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   lbse_evaluator lbse_evaluator_inst (.clk(clk), .rst_n(rst_n), .runEnable(runEnable),
      .running(running), .first_scan_flag(first_scan_flag), .scanDone(scanDone), .pc(pc),
      .instr(instr), .sigRdEn(sigRdEn), .sigArea(sigArea), .sigByte(sigByte), .sigBit(sigBit),
      .sigValue(sigValue), .coilWrEn(coilWrEn), .coilArea(coilArea), .coilByte(coilByte),
      .coilBit(coilBit), .coilData(coilData), .operandErr(operandErr),
      .illegalStore(illegalStore), .stack_top_view(stack_top_view), .areaRdEn(areaRdEn),
      .areaWrEn(areaWrEn), .areaSel(areaSel), .areaAddr(areaAddr), .areaWrData(areaWrData),
      .areaRdData(areaRdData), .areaRdValid(areaRdValid), .areaWrRefused(areaWrRefused),
      .presetLoadEn(presetLoadEn), .presetLoadCounter(presetLoadCounter),
      .presetLoadAddr(presetLoadAddr), .presetLoadData(presetLoadData));
   lbse_ladder_env lbse_ladder_env_inst (.clk(clk), .pc(pc), .instr(instr),
      .sigRdEn(sigRdEn), .sigArea(sigArea), .sigByte(sigByte), .sigBit(sigBit),
      .sigValue(sigValue));
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (coilWrEn === 1'b1) coils.push_back({coilArea, coilByte, coilBit, coilData});
      if (operandErr === 1'b1) nErr <= nErr + 1;
      if (illegalStore === 1'b1) nIll <= nIll + 1;
      if (cycles == 4000) begin
         n_mismatch = n_mismatch + 1;
         finish_test();
      end
   end
   task automatic chk_v(input string nm, input logic [16:0] e, input logic [16:0] g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_f(input string nm, input logic e, input logic g);
      chk_v(nm, {16'h0000, e}, {16'h0000, g});
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic do_reset();
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
   endtask
   task automatic put(int i, lbse_op_t o, logic [2:0] a, logic [9:0] b, logic [2:0] t);
      lbse_ladder_env_inst.prog[i] = {o, a, b, t};
   endtask
   task automatic clear_prog();
      for (int i = 0; i < 64; i++) put(i, OP_END_SCAN, 3'h0, 10'h000, 3'h0);
   endtask
   // one scan from reset; start pulse is dropped so the sequencer idles after it
   task automatic run_scan();
      int k;
      do_reset();
      coils.delete();
      nErr = 0;
      nIll = 0;
      chk_f("first scan set", 1'b1, first_scan_flag);
      @(posedge clk);
      #1 runEnable = 1'b1;
      @(posedge clk);
      #1 runEnable = 1'b0;
      k = 0;
      while (scanDone !== 1'b1 && k < 100) begin
         @(posedge clk);
         #1 k++;
      end
      chk_f("scan done", 1'b1, scanDone);
      chk_f("first scan clear", 1'b0, first_scan_flag);
   endtask
   // contacts on bit 1 read as one, bit 0 as zero
   task automatic t_logic();
      clear_prog();
      put(0, OP_LOAD, 3'h2, 10'h000, 3'h1);
      put(1, OP_LOAD_INV, 3'h2, 10'h000, 3'h1);
      put(2, OP_OR, 3'h2, 10'h000, 3'h1);
      put(3, OP_AND_INV, 3'h2, 10'h000, 3'h1);
      put(4, OP_STACK_OR, 3'h0, 10'h000, 3'h0);
      put(5, OP_OR_INV, 3'h2, 10'h000, 3'h1);
      put(6, OP_STORE, 3'h2, 10'h005, 3'h3);
      put(7, OP_STORE_INV, 3'h2, 10'h006, 3'h4);
      run_scan();
      chk_v("stack", 17'h00001, {9'h000, stack_top_view});
      chk_v("coil count", 17'h00002, 17'(coils.size()));
      chk_v("coil one", {3'h2, 10'h005, 3'h3, 1'b1}, coils[0]);
      chk_v("coil two", {3'h2, 10'h006, 3'h4, 1'b0}, coils[1]);
   endtask
   task automatic t_deep();
      clear_prog();
      // oldest bit ends up one so a pop that keeps it instead of zero shows
      for (int i = 0; i < 9; i++) put(i, OP_LOAD, 3'h2, 10'h000, {2'b00, i[0]});
      put(9, OP_STACK_AND, 3'h0, 10'h000, 3'h0);
      put(10, OP_STACK_OR, 3'h0, 10'h000, 3'h0);
      run_scan();
      chk_v("deep stack", 17'h0002A, {9'h000, stack_top_view});
   endtask
   task automatic t_faults();
      clear_prog();
      put(0, OP_LABEL_DECL, 3'h0, 10'h063, 3'h0);
      put(1, OP_JUMP_LABEL, 3'h0, 10'h064, 3'h0);
      put(2, OP_CALL_SUB, 3'h0, 10'h064, 3'h0);
      put(3, OP_SUB_BEGIN, 3'h0, 10'h063, 3'h0);
      put(4, OP_STORE, AREA_INPUT, 10'h001, 3'h0);
      put(5, OP_STORE_INV, AREA_FROM_CNC, 10'h001, 3'h0);
      run_scan();
      chk_v("operand faults", 17'h00002, 17'(nErr));
      chk_v("illegal stores", 17'h00002, 17'(nIll));
      chk_v("coil count", 17'h00000, 17'(coils.size()));
   endtask
   task automatic preset_ld(logic c, logic [6:0] a, logic [15:0] d);
      @(posedge clk);
      #1 {presetLoadEn, presetLoadCounter, presetLoadAddr, presetLoadData} = {1'b1, c, a, d};
      @(posedge clk);
      #1 presetLoadEn = 1'b0;
   endtask
   task automatic area_wr(logic [1:0] s, logic [7:0] a, logic [15:0] d, logic rf);
      @(posedge clk);
      #1 {areaWrEn, areaSel, areaAddr, areaWrData} = {1'b1, s, a, d};
      @(posedge clk);
      #1 areaWrEn = 1'b0;
      chk_f("write refused", rf, areaWrRefused);
   endtask
   task automatic area_rd(logic [1:0] s, logic [7:0] a, logic [15:0] e);
      @(posedge clk);
      #1 {areaRdEn, areaSel, areaAddr} = {1'b1, s, a};
      @(posedge clk);
      #1 areaRdEn = 1'b0;
      chk_f("read valid", 1'b1, areaRdValid);
      chk_v("read data", {1'b0, e}, {1'b0, areaRdData});
   endtask
   // reset stands in for power loss here
   task automatic t_area();
      do_reset();
      preset_ld(1'b0, 7'h7F, 16'h1234);
      preset_ld(1'b1, 7'h00, 16'hABCD);
      area_wr(SEL_TABLE, 8'hFF, 16'h5A3C, 1'b0);
      area_rd(SEL_TABLE, 8'hFF, 16'h5A3C);
      area_rd(SEL_TMR_CUR, 8'h7F, 16'h1234);
      area_wr(SEL_TMR_CUR, 8'h7F, 16'h0042, 1'b0);
      area_rd(SEL_TMR_CUR, 8'h7F, 16'h0042);
      area_wr(SEL_TMR_CUR, 8'h80, 16'h0001, 1'b1);
      area_wr(SEL_TMR_PRE, 8'h7F, 16'h0000, 1'b1);
      area_wr(SEL_CNT_PRE, 8'h00, 16'h0000, 1'b1);
      area_rd(SEL_TMR_PRE, 8'h7F, 16'h1234);
      area_wr(SEL_TMR_CUR, 8'h7F, 16'h0000, 1'b0);
      area_rd(SEL_TMR_CUR, 8'h7F, 16'h1234);
      area_wr(SEL_TMR_CUR, 8'h7F, 16'h0042, 1'b0);
      do_reset();
      area_rd(SEL_TMR_CUR, 8'h7F, 16'h1234);
      area_rd(SEL_TABLE, 8'hFF, 16'h5A3C);
      area_rd(SEL_CNT_PRE, 8'h00, 16'hABCD);
      area_rd(SEL_TMR_PRE, 8'h7F, 16'h1234);
   endtask
   initial begin
      {rst_n, runEnable, areaRdEn, areaWrEn, presetLoadEn, presetLoadCounter} = '0;
      {areaSel, areaAddr, areaWrData, presetLoadAddr, presetLoadData} = '0;
      {n_mismatch, n_compared, cycles, nErr, nIll} = '0;
      t_logic();
      t_deep();
      t_faults();
      t_area();
      finish_test();
   end
endmodule
